//--- hdl/dhife_pkg.sv
// Shared constants, mode type and strap decode for the host interface front end.
// Assumes straps are presented as {bit2, bit1, bit0}.
package dhife_pkg;

  // ****************************************
  // Widths and bus bit positions
  // ****************************************
  localparam int unsigned BUS_W       = 8;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned SER_CLK_BIT = 0;
  localparam int unsigned SER_DAT_BIT = 1;
  localparam int unsigned SDA_OUT_BIT = 2;

  localparam logic [BUS_W-1:0] BUS_ZERO = 8'h00;
  localparam logic [BUS_W-1:0] OE_NONE  = 8'h00;
  localparam logic [BUS_W-1:0] OE_ALL   = 8'hff;
  localparam logic [BUS_W-1:0] OE_SDA   = 8'h04;

  // ****************************************
  // Strap codes, written {bit2, bit1, bit0}
  // ****************************************
  localparam logic [2:0] STRAP_I2C  = 3'h2;
  localparam logic [2:0] STRAP_SPI3 = 3'h1;
  localparam logic [2:0] STRAP_SPI4 = 3'h0;
  localparam logic [2:0] STRAP_P68  = 3'h4;
  localparam logic [2:0] STRAP_P80  = 3'h6;

  typedef enum logic [2:0] {
    mode_i2c,
    mode_spi3,
    mode_spi4,
    mode_p68,
    mode_p80,
    mode_bad
  } dhife_mode_t;

  // Straps with no defined protocol fall to mode_bad, which accepts nothing
  function automatic dhife_mode_t decode_mode(input logic [2:0] strap);
    dhife_mode_t m;
    m = mode_bad;
    if (strap == STRAP_I2C) begin
      m = mode_i2c;
    end else if (strap == STRAP_SPI3) begin
      m = mode_spi3;
    end else if (strap == STRAP_SPI4) begin
      m = mode_spi4;
    end else if (strap == STRAP_P68) begin
      m = mode_p68;
    end else if (strap == STRAP_P80) begin
      m = mode_p80;
    end
    return m;
  endfunction

endpackage

//--- hdl/dhife_pin_if.sv
// Synchronised host pins passed from the top to the strobe decoder.
// Assumes every member already crossed into the system clock domain.
interface dhife_pin_if;
  logic                        cs_n;
  logic                        dc;
  logic                        rw;
  logic                        e_rd;
  logic [dhife_pkg::BUS_W-1:0] data;

  modport src (output cs_n, output dc, output rw, output e_rd, output data);
  modport dst (input cs_n, input dc, input rw, input e_rd, input data);
endinterface

//--- hdl/dhife_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the group needs no mutual coherence; each bit crosses alone.
module dhife_sync #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // ****************************************
  // Stages
  // ****************************************
  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      meta_r <= i_d;
      q_r    <= meta_r;
    end
  end

  assign o_q = q_r;

endmodule

//--- hdl/dhife_strobe.sv
// Parallel strobe decoder for the 68-style and 80-style host buses.
// Assumes synchronised pins and a mode that is stable outside reset.
module dhife_strobe (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  input  wire dhife_pkg::dhife_mode_t      i_mode,
  dhife_pin_if.dst                         pins,
  output logic                             o_wr_pulse,
  output logic [dhife_pkg::BUS_W-1:0]      o_wr_byte,
  output logic                             o_wr_dc,
  output logic                             o_rd_start,
  output logic                             o_rd_end,
  output logic                             o_rd_active,
  output logic                             o_rd_dc
);

  // ****************************************
  // Strobe decode
  // ****************************************
  wire sel      = !pins.cs_n;
  wire is_p68   = (i_mode == dhife_pkg::mode_p68);
  wire is_p80   = (i_mode == dhife_pkg::mode_p80);
  wire e68_act  = is_p68 && sel && pins.e_rd;
  wire wr68     = e68_act && !pins.rw;
  wire rd68     = e68_act && pins.rw;
  wire wr80     = is_p80 && sel && !pins.rw;
  wire rd80     = is_p80 && sel && !pins.e_rd;
  wire wr_act   = wr68 || wr80;
  wire rd_act   = rd68 || rd80;

  logic                        wr_act_r;
  logic                        rd_act_r;
  logic [dhife_pkg::BUS_W-1:0] hold_byte_r;
  logic                        hold_dc_r;
  logic                        wr_pulse_r;
  logic [dhife_pkg::BUS_W-1:0] wr_byte_r;
  logic                        wr_dc_r;
  logic                        rd_dc_r;

  // Trailing edge is seen one cycle late, so the byte held during the strobe is used
  wire wr_end   = wr_act_r && !wr_act;
  wire rd_begin = rd_act && !rd_act_r;

  // ****************************************
  // Capture
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_act_r    <= 1'b0;
      rd_act_r    <= 1'b0;
      hold_byte_r <= dhife_pkg::BUS_ZERO;
      hold_dc_r   <= 1'b0;
      wr_pulse_r  <= 1'b0;
      wr_byte_r   <= dhife_pkg::BUS_ZERO;
      wr_dc_r     <= 1'b0;
      rd_dc_r     <= 1'b0;
    end else begin
      wr_act_r   <= wr_act;
      rd_act_r   <= rd_act;
      wr_pulse_r <= wr_end;
      if (wr_act) begin
        hold_byte_r <= pins.data;
        hold_dc_r   <= pins.dc;
      end
      if (wr_end) begin
        wr_byte_r <= hold_byte_r;
        wr_dc_r   <= hold_dc_r;
      end
      if (rd_begin) begin
        rd_dc_r <= pins.dc;
      end
    end
  end

  assign o_wr_pulse  = wr_pulse_r;
  assign o_wr_byte   = wr_byte_r;
  assign o_wr_dc     = wr_dc_r;
  assign o_rd_start  = rd_begin;
  assign o_rd_end    = rd_act_r && !rd_act;
  assign o_rd_active = rd_act;
  assign o_rd_dc     = rd_begin ? pins.dc : rd_dc_r;

endmodule

//--- hdl/dhife_top.sv
// Host interface front end: protocol straps, chip init, parallel routing, serial and I2C pin mapping.
// Assumes all host pins are asynchronous to i_clk_sys and the serial engines sit downstream.
module dhife_top (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_init_reset_n,
  input  wire logic                        i_proto_sel_bit0,
  input  wire logic                        i_proto_sel_bit1,
  input  wire logic                        i_proto_sel_bit2,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_dc,
  input  wire logic                        i_rw,
  input  wire logic                        i_e_rd,
  input  wire logic [dhife_pkg::BUS_W-1:0] i_host_data_bus,
  output logic      [dhife_pkg::BUS_W-1:0] o_host_data_bus,
  output logic      [dhife_pkg::BUS_W-1:0] o_host_data_oe,
  input  wire logic [dhife_pkg::BUS_W-1:0] i_rd_data,
  input  wire logic                        i_i2c_sda_low,
  output dhife_pkg::dhife_mode_t           o_mode,
  output logic                             o_mode_bad,
  output logic                             o_chip_init,
  output logic                             o_cmd_valid,
  output logic      [dhife_pkg::BUS_W-1:0] o_cmd_byte,
  output logic                             o_disp_valid,
  output logic      [dhife_pkg::BUS_W-1:0] o_disp_byte,
  output logic                             o_rd_req,
  output logic                             o_rd_is_data,
  output logic                             o_rd_done,
  output logic                             o_ser_sel,
  output logic                             o_ser_clk,
  output logic                             o_serial_data_in,
  output logic                             o_ser_is_data,
  output logic                             o_i2c_scl,
  output logic                             o_i2c_sda_in,
  output logic                             o_slave_addr_lsb
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int unsigned CTL_W = 4;
  localparam logic [CTL_W-1:0] CTL_IDLE = 4'hf;
  // Positions of the control pins inside the synchronised group
  localparam int unsigned CTL_CS_BIT = 3;
  localparam int unsigned CTL_DC_BIT = 2;
  localparam int unsigned CTL_RW_BIT = 1;
  localparam int unsigned CTL_E_BIT  = 0;

  logic                        init_n_s;
  logic [2:0]                  strap_s;
  logic [CTL_W-1:0]            ctl_s;
  logic [dhife_pkg::BUS_W-1:0] data_s;

  // The init pin syncs on the system reset alone so it can hold everything else
  dhife_sync #(.W(1), .RST_VAL(1'b0)) u_sync_init (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_d       (i_init_reset_n),
    .o_q       (init_n_s)
  );

  // Straps must be seen while reset is held, so this synchroniser never resets
  dhife_sync #(.W(3), .RST_VAL(3'h0)) u_sync_strap (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (1'b1),
    .i_d       ({i_proto_sel_bit2, i_proto_sel_bit1, i_proto_sel_bit0}),
    .o_q       (strap_s)
  );

  // Control pins idle high so no strobe is seen coming out of reset
  dhife_sync #(.W(CTL_W), .RST_VAL(CTL_IDLE)) u_sync_ctl (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_d       ({i_cs_n, i_dc, i_rw, i_e_rd}),
    .o_q       (ctl_s)
  );

  dhife_sync #(.W(dhife_pkg::BUS_W), .RST_VAL(dhife_pkg::BUS_ZERO)) u_sync_data (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_d       (i_host_data_bus),
    .o_q       (data_s)
  );

  // ****************************************
  // Chip init and mode
  // ****************************************
  wire run_n = i_rst_n && init_n_s;

  dhife_pkg::dhife_mode_t mode_r;
  wire dhife_pkg::dhife_mode_t strap_mode = dhife_pkg::decode_mode(strap_s);

  // Straps are caught throughout init and frozen once it ends
  always_ff @(posedge i_clk_sys) begin
    if (!run_n) begin
      mode_r <= strap_mode;
    end
  end

  // Both wire counts share one serial path; the engine downstream tells them apart
  function automatic logic mode_is_serial(input dhife_pkg::dhife_mode_t m);
    return (m == dhife_pkg::mode_spi3) || (m == dhife_pkg::mode_spi4);
  endfunction

  wire is_i2c    = (mode_r == dhife_pkg::mode_i2c);
  wire is_serial = mode_is_serial(mode_r);

  // ****************************************
  // Parallel strobes
  // ****************************************
  dhife_pin_if pins ();

  assign pins.cs_n = ctl_s[CTL_CS_BIT];
  assign pins.dc   = ctl_s[CTL_DC_BIT];
  assign pins.rw   = ctl_s[CTL_RW_BIT];
  assign pins.e_rd = ctl_s[CTL_E_BIT];
  assign pins.data = data_s;

  logic                        wr_pulse;
  logic [dhife_pkg::BUS_W-1:0] wr_byte;
  logic                        wr_dc;
  logic                        rd_start;
  logic                        rd_end;
  logic                        rd_active;
  logic                        rd_dc;

  dhife_strobe u_strobe (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (run_n),
    .i_mode      (mode_r),
    .pins        (pins),
    .o_wr_pulse  (wr_pulse),
    .o_wr_byte   (wr_byte),
    .o_wr_dc     (wr_dc),
    .o_rd_start  (rd_start),
    .o_rd_end    (rd_end),
    .o_rd_active (rd_active),
    .o_rd_dc     (rd_dc)
  );

  // ****************************************
  // Write routing
  // ****************************************
  logic                        cmd_valid_r;
  logic [dhife_pkg::BUS_W-1:0] cmd_byte_r;
  logic                        disp_valid_r;
  logic [dhife_pkg::BUS_W-1:0] disp_byte_r;

  // Data/command level picks the destination of each finished write
  wire cmd_take  = wr_pulse && !wr_dc;
  wire disp_take = wr_pulse && wr_dc;

  always_ff @(posedge i_clk_sys) begin
    if (!run_n) begin
      cmd_valid_r  <= 1'b0;
      cmd_byte_r   <= dhife_pkg::BUS_ZERO;
      disp_valid_r <= 1'b0;
      disp_byte_r  <= dhife_pkg::BUS_ZERO;
    end else begin
      cmd_valid_r  <= cmd_take;
      disp_valid_r <= disp_take;
      if (cmd_take) begin
        cmd_byte_r <= wr_byte;
      end
      if (disp_take) begin
        disp_byte_r <= wr_byte;
      end
    end
  end

  // ****************************************
  // Read path and bus drive
  // ****************************************
  logic                        rd_req_r;
  logic                        rd_is_data_r;
  logic                        rd_done_r;
  logic [dhife_pkg::BUS_W-1:0] bus_out_r;
  logic [dhife_pkg::BUS_W-1:0] bus_oe_r;

  // I2C acknowledge and read data leave on bit 2 only; the line is pulled low, never driven high
  wire sda_drive = is_i2c && i_i2c_sda_low;

  logic [dhife_pkg::BUS_W-1:0] bus_out_nxt;
  logic [dhife_pkg::BUS_W-1:0] bus_oe_nxt;
  logic                        rd_is_data_nxt;

  // A read owns the whole bus, so the I2C pull only shows when no read runs
  assign bus_out_nxt    = rd_active ? i_rd_data : dhife_pkg::BUS_ZERO;
  assign bus_oe_nxt     = rd_active ? dhife_pkg::OE_ALL :
                          (sda_drive ? dhife_pkg::OE_SDA : dhife_pkg::OE_NONE);
  assign rd_is_data_nxt = rd_start ? rd_dc : rd_is_data_r;

  always_ff @(posedge i_clk_sys) begin
    if (!run_n) begin
      rd_req_r     <= 1'b0;
      rd_is_data_r <= 1'b0;
      rd_done_r    <= 1'b0;
      bus_out_r    <= dhife_pkg::BUS_ZERO;
      bus_oe_r     <= dhife_pkg::OE_NONE;
    end else begin
      rd_req_r     <= rd_start;
      rd_done_r    <= rd_end;
      rd_is_data_r <= rd_is_data_nxt;
      bus_out_r    <= bus_out_nxt;
      bus_oe_r     <= bus_oe_nxt;
    end
  end

  // ****************************************
  // Serial and I2C pin mapping
  // ****************************************
  logic ser_sel_r;
  logic ser_clk_r;
  logic ser_dat_r;
  logic ser_dc_r;
  logic scl_r;
  logic sda_in_r;
  logic sa_lsb_r;

  // Each line shows its pin only in its own mode and idles elsewhere
  wire ser_sel_nxt = is_serial && !pins.cs_n;
  wire ser_clk_nxt = is_serial ? data_s[dhife_pkg::SER_CLK_BIT] : 1'b1;
  wire ser_dat_nxt = is_serial ? data_s[dhife_pkg::SER_DAT_BIT] : 1'b1;
  wire ser_dc_nxt  = is_serial && pins.dc;
  wire scl_nxt     = is_i2c ? data_s[dhife_pkg::SER_CLK_BIT] : 1'b1;
  wire sda_in_nxt  = is_i2c ? data_s[dhife_pkg::SER_DAT_BIT] : 1'b1;
  wire sa_lsb_nxt  = is_i2c && pins.dc;

  // Idle-high defaults keep a downstream engine from seeing a false clock edge
  always_ff @(posedge i_clk_sys) begin
    if (!run_n) begin
      ser_sel_r <= 1'b0;
      ser_clk_r <= 1'b1;
      ser_dat_r <= 1'b1;
      ser_dc_r  <= 1'b0;
      scl_r     <= 1'b1;
      sda_in_r  <= 1'b1;
      sa_lsb_r  <= 1'b0;
    end else begin
      ser_sel_r <= ser_sel_nxt;
      ser_clk_r <= ser_clk_nxt;
      ser_dat_r <= ser_dat_nxt;
      ser_dc_r  <= ser_dc_nxt;
      scl_r     <= scl_nxt;
      sda_in_r  <= sda_in_nxt;
      sa_lsb_r  <= sa_lsb_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_host_data_bus  = bus_out_r;
  assign o_host_data_oe   = bus_oe_r;
  assign o_mode           = mode_r;
  assign o_mode_bad       = (mode_r == dhife_pkg::mode_bad);
  assign o_chip_init      = !run_n;
  assign o_cmd_valid      = cmd_valid_r;
  assign o_cmd_byte       = cmd_byte_r;
  assign o_disp_valid     = disp_valid_r;
  assign o_disp_byte      = disp_byte_r;
  assign o_rd_req         = rd_req_r;
  assign o_rd_is_data     = rd_is_data_r;
  assign o_rd_done        = rd_done_r;
  assign o_ser_sel        = ser_sel_r;
  assign o_ser_clk        = ser_clk_r;
  assign o_serial_data_in = ser_dat_r;
  assign o_ser_is_data    = ser_dc_r;
  assign o_i2c_scl        = scl_r;
  assign o_i2c_sda_in     = sda_in_r;
  assign o_slave_addr_lsb = sa_lsb_r;

endmodule

//--- sim/dhife_chk.sv
// Port checker for the host interface front end
// Assumes binding onto dhife_top; sees its ports only
module dhife_chk (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst_n,
  input wire logic                   i_cs_n,
  input wire logic                   i_dc,
  input wire logic [7:0]             i_host_data_bus,
  input wire logic [7:0]             i_rd_data,
  input wire logic                   i_i2c_sda_low,
  input wire logic [7:0]             o_host_data_bus,
  input wire logic [7:0]             o_host_data_oe,
  input wire dhife_pkg::dhife_mode_t o_mode,
  input wire logic                   o_chip_init,
  input wire logic                   o_cmd_valid,
  input wire logic                   o_disp_valid,
  input wire logic                   o_rd_req,
  input wire logic                   o_ser_is_data,
  input wire logic                   o_i2c_scl,
  input wire logic                   o_slave_addr_lsb
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  // Pin levels need four quiet cycles: two sync flops, a register and slack
  wire i2c = o_mode == dhife_pkg::mode_i2c && !o_chip_init;
  wire spi = (o_mode == dhife_pkg::mode_spi3 || o_mode == dhife_pkg::mode_spi4) && !o_chip_init;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  AST_ONE_DEST: assert property (!(o_cmd_valid && o_disp_valid))
    else $error("command and display strobes together");
  AST_CMD_PULSE: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("command strobe longer than one cycle");
  AST_DISP_PULSE: assert property (o_disp_valid |=> !o_disp_valid)
    else $error("display strobe longer than one cycle");
  AST_NO_SEL: assert property (i_cs_n [*8] |-> !(o_cmd_valid || o_disp_valid || o_rd_req))
    else $error("transfer without chip select");
  AST_RD_DRIVE: assert property (o_rd_req |-> o_host_data_oe == 8'hff && o_host_data_bus == $past(i_rd_data))
    else $error("read data not driven");
  AST_SA_LSB: assert property ((i2c && $stable(i_dc)) [*4] |-> o_slave_addr_lsb == i_dc)
    else $error("address bit does not follow pin");
  AST_SER_DC: assert property ((spi && $stable(i_dc)) [*4] |-> o_ser_is_data == i_dc)
    else $error("serial steering does not follow pin");
  AST_SCL: assert property ((i2c && $stable(i_host_data_bus[0])) [*4] |-> o_i2c_scl == i_host_data_bus[0])
    else $error("clock line not forwarded");
  AST_SDA_PULL: assert property ((i2c && i_i2c_sda_low) [*2] |-> o_host_data_oe == 8'h04 && !o_host_data_bus[2])
    else $error("data line not pulled low");
  AST_INIT: assert property (disable iff (1'b0) !i_rst_n |-> o_chip_init)
    else $error("init flag low in reset");
  AST_INIT_QUIET: assert property (o_chip_init |=> !(o_cmd_valid || o_disp_valid || o_rd_req))
    else $error("activity right after init");
  cover property (o_cmd_valid);
  cover property (o_disp_valid);
  cover property (o_rd_req);
endmodule

bind dhife_top dhife_chk dhife_chk_inst (.i_clk_sys, .i_rst_n, .i_cs_n, .i_dc, .i_host_data_bus, .i_rd_data,
  .i_i2c_sda_low, .o_host_data_bus, .o_host_data_oe, .o_mode, .o_chip_init, .o_cmd_valid, .o_disp_valid,
  .o_rd_req, .o_ser_is_data, .o_i2c_scl, .o_slave_addr_lsb);

//--- sim/dhife_host.sv
// Host controller model driving the parallel and serial pins
// Assumes the bench selects 80 style through i_p80
module dhife_host (
  input  wire logic       i_clk,
  input  wire logic       i_p80,
  output logic            o_cs_n,
  output logic            o_dc,
  output logic            o_rw,
  output logic            o_e_rd,
  output logic [7:0]      o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Transfers
  // ****
  initial begin
    o_cs_n = 1'b1;
    o_dc = 1'b0;
    o_rw = 1'b1;
    o_e_rd = 1'b0;
    o_data = 8'h00;
  end
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] b, input logic sel);
    @(posedge i_clk);
    o_cs_n <= !sel;
    o_dc <= dc;
    o_data <= rd ? ~o_data : b;
    o_rw <= i_p80 | rd;
    o_e_rd <= i_p80;
    @(posedge i_clk);
    if (i_p80) begin
      o_rw <= rd;
      o_e_rd <= !rd;
    end else begin
      o_e_rd <= 1'b1;
    end
    repeat (5) @(posedge i_clk);
    o_rw <= i_p80 | rd;
    o_e_rd <= i_p80;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    // Released lines flip so a stale byte can never pass for a fresh one
    o_data <= ~o_data;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic lines(input logic cs, input logic dc, input logic [7:0] b);
    @(posedge i_clk);
    o_cs_n <= cs;
    o_dc <= dc;
    o_data <= b;
  endtask
endmodule

//--- sim/dhife_tb.sv
// Self-checking bench for the host interface front end
// Assumes the host model and the bound checker compile first
module dhife_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, init_n, p80, sda_low, cs_n, dc, rw, e_rd, rd_ok, r, d, s, rdone;
  logic       mode_bad, chip_init, cmd_v, disp_v, rd_req, rd_isd, ser_sel, ser_clk, ser_d, ser_isd, scl, sda_in, sa;
  logic [2:0] strap;
  logic [7:0] rd_data, hdata, bus_o, oe, bus_in, cmd_b, disp_b, b;
  int         mismatches, total_checks, seed, ncmd, ndisp, nrd, c0, d0, r0, k, ndone, n0;
  dhife_pkg::dhife_mode_t mode;
  // ****
  // Wiring
  // ****
  assign bus_in = (oe & bus_o) | (~oe & hdata);
  dhife_host dhife_host_inst (.i_clk(clk), .i_p80(p80), .o_cs_n(cs_n), .o_dc(dc), .o_rw(rw), .o_e_rd(e_rd),
    .o_data(hdata));
  dhife_top dhife_top_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_init_reset_n(init_n),
    .i_proto_sel_bit0(strap[0]), .i_proto_sel_bit1(strap[1]), .i_proto_sel_bit2(strap[2]),
    .i_cs_n(cs_n), .i_dc(dc), .i_rw(rw), .i_e_rd(e_rd), .i_host_data_bus(bus_in), .o_host_data_bus(bus_o),
    .o_host_data_oe(oe), .i_rd_data(rd_data), .i_i2c_sda_low(sda_low), .o_mode(mode), .o_mode_bad(mode_bad),
    .o_chip_init(chip_init), .o_cmd_valid(cmd_v), .o_cmd_byte(cmd_b), .o_disp_valid(disp_v),
    .o_disp_byte(disp_b), .o_rd_req(rd_req), .o_rd_is_data(rd_isd), .o_rd_done(rdone), .o_ser_sel(ser_sel),
    .o_ser_clk(ser_clk), .o_serial_data_in(ser_d), .o_ser_is_data(ser_isd), .o_i2c_scl(scl),
    .o_i2c_sda_in(sda_in), .o_slave_addr_lsb(sa));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cmd_v === 1'b1) ncmd <= ncmd + 1;
    if (disp_v === 1'b1) ndisp <= ndisp + 1;
    if (rdone === 1'b1) ndone <= ndone + 1;
    if (rd_req === 1'b1) begin
      nrd <= nrd + 1;
      rd_ok <= (bus_o === rd_data) && (oe === 8'hff);
    end
  end
  // ****
  // Helpers
  // ****
  function automatic dhife_pkg::dhife_mode_t exp_mode(input logic [2:0] st);
    case (st)
      3'h2: return dhife_pkg::mode_i2c;
      3'h1: return dhife_pkg::mode_spi3;
      3'h0: return dhife_pkg::mode_spi4;
      3'h4: return dhife_pkg::mode_p68;
      3'h6: return dhife_pkg::mode_p80;
      default: return dhife_pkg::mode_bad;
    endcase
  endfunction
  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic restart(input logic [2:0] st);
    rst_n <= 1'b0;
    strap <= st;
    p80 <= (st == 3'h6);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    seed = 32'h5d30;
    {mismatches, total_checks, ncmd, ndisp, nrd, ndone} = '0;
    {rst_n, init_n, p80, sda_low, strap, rd_data} = 15'h2000;
    for (k = 0; k < 8; k++) begin
      restart(k[2:0]);
      chk(mode === exp_mode(k[2:0]), "mode");
      chk(mode_bad === (exp_mode(k[2:0]) == dhife_pkg::mode_bad), "bad flag");
    end
    for (k = 0; k < 2; k++) begin
      restart(k ? 3'h6 : 3'h4);
      repeat (14) begin
        {r, d, s} = 3'($random(seed));
        b = 8'($random(seed));
        rd_data <= 8'($random(seed));
        {c0, d0, r0, n0} = {ncmd, ndisp, nrd, ndone};
        dhife_host_inst.xfer(r, d, b, s);
        // The answer lands about five cycles after the strobe ends
        repeat (6) @(posedge clk);
        chk(ncmd == c0 + int'(s & !r & !d) && ndisp == d0 + int'(s & !r & d) && nrd == r0 + int'(s & r), "count");
        if (s && !r) chk((d ? disp_b : cmd_b) === b, "byte");
        if (s && r) chk(rd_ok === 1'b1 && rd_isd === d, "read");
        chk(ndone == n0 + int'(s & r) && oe === 8'h00, "read end");
      end
    end
    init_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(chip_init === 1'b1, "init high");
    init_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(chip_init === 1'b0 && mode === dhife_pkg::mode_p80, "init end");
    for (k = 0; k < 3; k++) begin
      restart(k[2:0]);
      repeat (8) begin
        {s, d} = 2'($random(seed));
        b = 8'($random(seed));
        sda_low <= b[7];
        dhife_host_inst.lines(s, d, b);
        repeat (5) @(posedge clk);
        if (k == 2) begin
          chk(sa === d && scl === b[0] && sda_in === b[1], "i2c pins");
          chk(oe === (b[7] ? 8'h04 : 8'h00), "sda pull");
        end else begin
          chk(ser_isd === d && ser_clk === b[0] && ser_d === b[1] && ser_sel === !s, "spi pins");
        end
      end
    end
    complete_run();
  end
endmodule
